// ==== hw/vlmp_protect.sv ====
// protection and mode control for legacy programs in virtual legacy mode
module vlmp_protect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fault_pulse,
  output logic [7:0] fault_vector,
  output logic [15:0] fault_code,
  output logic virtual_mode_flag,
  output logic segment_legacy_base
);

  // ****************************************
  // state, record memory and helpers
  // ****************************************
  vlmp_pkg::vlmp_state_type st;
  vlmp_pkg::vlmp_state_type next_st;
  logic [7:0] record [256];
  logic wr_fire;
  logic cmd_fire;
  logic rec_hit;
  vlmp_pkg::vlmp_cmd_type cmd;
  logic vm;
  logic [1:0] cpl_eff;
  logic io_privilege_level_bad;

  // transfer completes at access phase with pready high
  assign wr_fire = psel & penable & st.pready & pwrite;
  assign cmd_fire = wr_fire & (paddr == vlmp_pkg::REG_COMMAND);
  assign rec_hit = paddr[11:10] == vlmp_pkg::RECORD_WINDOW;
  assign cmd = vlmp_pkg::vlmp_cmd_type'(pwdata[4:0]);
  assign vm = st.flags[vlmp_pkg::VM_POS];
  // virtual mode forces level 3, real mode runs at level 0
  assign cpl_eff = vm ? 2'h3 : (st.pe ? st.current_privilege : 2'h0);
  assign io_privilege_level_bad = cpl_eff > st.flags[vlmp_pkg::IO_PRIVILEGE_LEVEL_POS +: 2];

  // one bitmap bit, with every out-of-limit case denying
  function automatic logic map_denied(input logic [15:0] port);
    logic [15:0] ptr;
    logic [16:0] off;
    ptr = {record[8'h67], record[vlmp_pkg::BITMAP_PTR_LO]};
    off = {1'b0, ptr} + {4'h0, port[15:3]};
    return (st.limit < vlmp_pkg::BITMAP_PTR_HI)
      | (off > {1'b0, st.limit})
      | (off >= vlmp_pkg::RECORD_END)
      | record[off[7:0]][port[2:0]];
  endfunction : map_denied

  // every byte covered by the access must be clear
  function automatic logic port_denied(input logic [31:0] opnd);
    logic [15:0] p;
    logic [1:0] sz;
    p = opnd[15:0];
    sz = opnd[vlmp_pkg::OPND_SIZE_POS +: 2];
    return map_denied(p)
      | ((sz != 2'h0) & map_denied(p + 16'h0001))
      | ((sz == 2'h2) & map_denied(p + 16'h0002))
      | ((sz == 2'h2) & map_denied(p + 16'h0003));
  endfunction : port_denied

  // ****************************************
  // next state: bus slave and instruction checks
  // ****************************************
  always_comb begin
    logic fault_now;
    logic [7:0] vec;
    logic [15:0] code;
    logic entry;
    fault_now = 1'b0;
    vec = vlmp_pkg::VEC_GP;
    code = 16'h0000;
    entry = 1'b0;
    next_st = st;
    next_st.fault_pulse = 1'b0;
    next_st.pready = psel & ~penable;
    // read data and error are prepared in the setup cycle
    if (psel & ~penable) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h00000000;
      case (paddr)
        vlmp_pkg::REG_MODE: next_st.prdata = {29'h0, st.current_privilege, st.pe};
        vlmp_pkg::REG_FLAGS: next_st.prdata = st.flags;
        vlmp_pkg::REG_OPERAND: next_st.prdata = st.operand;
        vlmp_pkg::REG_GATE: next_st.prdata = st.gate;
        vlmp_pkg::REG_COMMAND: next_st.prdata = 32'h00000000;
        vlmp_pkg::REG_RESULT: begin
          next_st.prdata = {st.code, st.vector, 6'h0, vm, st.fault};
        end
        vlmp_pkg::REG_IMAGE: next_st.prdata = st.image;
        vlmp_pkg::REG_LIMIT: next_st.prdata = {16'h0, st.limit};
        default: begin
          if (rec_hit) begin
            next_st.prdata = {24'h0, record[paddr[9:2]]};
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
      endcase
    end
    // register writes; the virtual flag is never written directly
    if (wr_fire) begin
      case (paddr)
        vlmp_pkg::REG_MODE: begin
          next_st.pe = pwdata[0];
          next_st.current_privilege = pwdata[2:1];
        end
        vlmp_pkg::REG_FLAGS: begin
          next_st.flags = pwdata;
          next_st.flags[vlmp_pkg::VM_POS] = vm;
        end
        vlmp_pkg::REG_OPERAND: next_st.operand = pwdata;
        vlmp_pkg::REG_GATE: next_st.gate = pwdata;
        vlmp_pkg::REG_LIMIT: next_st.limit = pwdata[15:0];
        default: next_st.limit = st.limit;
      endcase
    end
    // instruction and event classes
    if (cmd_fire) begin
      case (cmd)
        vlmp_pkg::CMD_PRIV: begin
          fault_now = cpl_eff != 2'h0;
        end
        vlmp_pkg::CMD_PROT_ONLY: begin
          fault_now = ~st.pe | vm;
          vec = vlmp_pkg::VEC_UD;
        end
        vlmp_pkg::CMD_STI, vlmp_pkg::CMD_CLI: begin
          fault_now = st.pe & io_privilege_level_bad;
          if (!fault_now) begin
            next_st.flags[vlmp_pkg::IF_POS] = cmd == vlmp_pkg::CMD_STI;
          end
        end
        vlmp_pkg::CMD_INT_N: begin
          fault_now = vm & io_privilege_level_bad;
          entry = ~fault_now;
        end
        vlmp_pkg::CMD_PUSH_STATUS_WORD: begin
          fault_now = vm & io_privilege_level_bad;
          if (!fault_now) begin
            next_st.image = st.flags;
            next_st.image[vlmp_pkg::VM_POS] = 1'b0;
          end
        end
        vlmp_pkg::CMD_POP_STATUS_WORD: begin
          fault_now = vm & io_privilege_level_bad;
          if (!fault_now) begin
            next_st.flags = st.operand;
            next_st.flags[vlmp_pkg::VM_POS] = vm;
          end
        end
        vlmp_pkg::CMD_INTERRUPT_RETURN: begin
          fault_now = vm & io_privilege_level_bad;
          if (!fault_now) begin
            if (!st.operand[vlmp_pkg::OPND_WIDE_POS]) begin
              next_st.flags[15:0] = st.gate[15:0];
            end else begin
              next_st.flags = st.gate;
              // only level 0 protected code may change the flag
              if (vm | ~st.pe | (st.current_privilege != 2'h0)) begin
                next_st.flags[vlmp_pkg::VM_POS] = vm;
              end else begin
                next_st.seg_legacy = st.gate[vlmp_pkg::VM_POS];
              end
            end
          end
        end
        vlmp_pkg::CMD_INT3, vlmp_pkg::CMD_INTO, vlmp_pkg::CMD_BOUND: begin
          fault_now = 1'b0;
        end
        vlmp_pkg::CMD_PORT: begin
          if (vm) begin
            fault_now = port_denied(st.operand);
          end else begin
            fault_now = st.pe & io_privilege_level_bad;
          end
        end
        vlmp_pkg::CMD_INTR: entry = 1'b1;
        vlmp_pkg::CMD_TASK: begin
          // outgoing status saved as is, flag included
          next_st.image = st.flags;
          if (st.gate[vlmp_pkg::GATE_TYPE_POS +: 4] ==
              vlmp_pkg::TYPE_NEW_AVAIL ||
              st.gate[vlmp_pkg::GATE_TYPE_POS +: 4] ==
              vlmp_pkg::TYPE_NEW_BUSY) begin
            next_st.flags = st.operand;
            // status first, then segment images as legacy bases
            next_st.seg_legacy = st.operand[vlmp_pkg::VM_POS];
          end else begin
            next_st.flags = {16'h0000, st.operand[15:0]};
            next_st.seg_legacy = 1'b0;
          end
        end
        default: fault_now = 1'b0;
      endcase
      // handler entry through the vector table gate
      if (entry && vm) begin
        if (st.gate[vlmp_pkg::GATE_CONF_POS] ||
            st.gate[vlmp_pkg::GATE_DPL_POS +: 2] != 2'h0) begin
          fault_now = 1'b1;
          code = st.gate[15:0];
        end else begin
          next_st.image = st.flags;
          next_st.flags[vlmp_pkg::VM_POS] = 1'b0;
          next_st.flags[vlmp_pkg::TF_POS] = 1'b0;
          if (st.gate[vlmp_pkg::GATE_INTR_POS]) begin
            next_st.flags[vlmp_pkg::IF_POS] = 1'b0;
          end
          next_st.current_privilege = 2'h0;
          next_st.seg_legacy = 1'b0;
        end
      end else if (entry) begin
        next_st.image = st.flags;
        next_st.flags[vlmp_pkg::TF_POS] = 1'b0;
      end
      next_st.fault = fault_now;
      next_st.fault_pulse = fault_now;
      next_st.vector = fault_now ? vec : 8'h00;
      next_st.code = code;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.flags <= vlmp_pkg::FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // record bytes written through the bus window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        record[i] <= 8'h00;
      end
    end else if (wr_fire && rec_hit) begin
      record[paddr[9:2]] <= pwdata[7:0];
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign fault_pulse = st.fault_pulse;
  assign fault_vector = st.vector;
  assign fault_code = st.code;
  assign virtual_mode_flag = st.flags[vlmp_pkg::VM_POS];
  assign segment_legacy_base = st.seg_legacy;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_priv_in_vm: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_PRIV && vm
    |=> fault_pulse && fault_vector == 8'h0d)
    else $error("privileged op in virtual mode did not fault");
  chk_priv_level: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_PRIV && st.pe && st.current_privilege == 2'h0 && !vm
    |=> !fault_pulse)
    else $error("privileged op faulted at level 0");
  chk_prot_only: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_PROT_ONLY && (vm || !st.pe)
    |=> fault_pulse && fault_vector == 8'h06)
    else $error("protected only op did not fault 6");
  chk_io_privilege_level_vm: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_POP_STATUS_WORD && vm
    && st.flags[13:12] != 2'h3 |=> fault_pulse && fault_vector == 8'h0d)
    else $error("io checked op passed below level 3 privilege");
  chk_no_io_check: assert property (
    cmd_fire && cmd inside {vlmp_pkg::CMD_INT3, vlmp_pkg::CMD_BOUND}
    |=> !fault_pulse)
    else $error("breakpoint or bounds took the io check");
  chk_pop_status_word_flag: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_POP_STATUS_WORD
    |=> virtual_mode_flag == $past(virtual_mode_flag))
    else $error("pop_status_word changed the virtual flag");
  chk_push_image: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_PUSH_STATUS_WORD ##1 !fault_pulse
    |-> !st.image[17])
    else $error("pushed image shows the virtual flag");
  chk_entry_clear: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_INTR && vm ##1 !fault_pulse
    |-> !virtual_mode_flag && st.image[17] && st.current_privilege == 2'h0)
    else $error("handler entry left the virtual flag set");
  chk_gate_fault: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_INTR && vm && st.gate[18]
    |=> fault_pulse && fault_code == $past(st.gate[15:0]) ##1 !fault_pulse)
    else $error("conforming gate did not fault with selector");
  chk_interrupt_return_enter: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_INTERRUPT_RETURN && st.pe && !vm
    && st.current_privilege == 2'h0 && st.operand[18] && st.gate[17]
    |=> virtual_mode_flag && segment_legacy_base)
    else $error("level 0 wide interrupt_return did not enter virtual mode");
  chk_old_task: assert property (
    cmd_fire && cmd == vlmp_pkg::CMD_TASK && st.gate[23:20] != 4'h9
    && st.gate[23:20] != 4'hb
    |=> !virtual_mode_flag)
    else $error("old format record resumed in virtual mode");

endmodule : vlmp_protect

// ==== hw/vlmp_pkg.sv ====
// constants and types shared by the legacy mode protection block
package vlmp_pkg;

  // ****************************************
  // register map on the apb bus
  // ****************************************
  localparam logic [11:0] REG_MODE = 12'h000;
  localparam logic [11:0] REG_FLAGS = 12'h004;
  localparam logic [11:0] REG_OPERAND = 12'h008;
  localparam logic [11:0] REG_GATE = 12'h00c;
  localparam logic [11:0] REG_COMMAND = 12'h010;
  localparam logic [11:0] REG_RESULT = 12'h014;
  localparam logic [11:0] REG_IMAGE = 12'h018;
  localparam logic [11:0] REG_LIMIT = 12'h01c;
  // task state record window: one byte per word, index in paddr[9:2]
  localparam logic [1:0] RECORD_WINDOW = 2'h1;
  localparam logic [16:0] RECORD_END = 17'h00100;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int VM_POS = 17;
  localparam int IO_PRIVILEGE_LEVEL_POS = 12;
  localparam int IF_POS = 9;
  localparam int TF_POS = 8;
  localparam logic [31:0] FLAGS_RESET = 32'h00000002;
  localparam logic [7:0] BITMAP_PTR_LO = 8'h66;
  localparam logic [15:0] BITMAP_PTR_HI = 16'h0067;
  // gate register fields
  localparam int GATE_DPL_POS = 16;
  localparam int GATE_CONF_POS = 18;
  localparam int GATE_INTR_POS = 19;
  localparam int GATE_TYPE_POS = 20;
  // operand register fields and new record type codes
  localparam int OPND_SIZE_POS = 16;
  localparam int OPND_WIDE_POS = 18;
  localparam logic [3:0] TYPE_NEW_AVAIL = 4'h9;
  localparam logic [3:0] TYPE_NEW_BUSY = 4'hb;

  // ****************************************
  // fault vectors and command classes
  // ****************************************
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_UD = 8'h06;

  typedef enum logic [4:0] {
    CMD_NONE = 5'h00,
    CMD_PRIV = 5'h01,
    CMD_PROT_ONLY = 5'h02,
    CMD_INT_N = 5'h03,
    CMD_STI = 5'h04,
    CMD_CLI = 5'h05,
    CMD_PUSH_STATUS_WORD = 5'h06,
    CMD_POP_STATUS_WORD = 5'h07,
    CMD_INTERRUPT_RETURN = 5'h08,
    CMD_INT3 = 5'h09,
    CMD_INTO = 5'h0a,
    CMD_BOUND = 5'h0b,
    CMD_PORT = 5'h0c,
    CMD_INTR = 5'h0d,
    CMD_TASK = 5'h0e
  } vlmp_cmd_type;

  typedef struct packed {
    logic pe;
    logic [1:0] current_privilege;
    logic [31:0] flags;
    logic [31:0] operand;
    logic [31:0] gate;
    logic [31:0] image;
    logic [15:0] limit;
    logic fault;
    logic [7:0] vector;
    logic [15:0] code;
    logic fault_pulse;
    logic seg_legacy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vlmp_state_type;

endpackage : vlmp_pkg

// ==== bench/tb_vlmp_protect.sv ====
// self-checking bench for the legacy mode protection block
module tb_vlmp_protect;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
  $display("wrong value %s exp %h got %h", nm, e, a); \
  err_count++; end end

  // ************************************
  // clock, reset and design
  // ************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_pulse;
  logic [7:0] fault_vector;
  logic [15:0] fault_code;
  logic virtual_mode_flag;
  logic segment_legacy_base;
  int err_count = 0;
  int n_tests = 0;
  logic vm = 1'b0;
  logic [7:0] rec [256];
  logic [15:0] lim;
  logic [31:0] rd;
  logic err_seen;
  logic fp_seen;
  int port;
  int sz;

  vlmp_protect uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_pulse(fault_pulse),
    .fault_vector(fault_vector), .fault_code(fault_code),
    .virtual_mode_flag(virtual_mode_flag),
    .segment_legacy_base(segment_legacy_base)
  );

  // free-running clock, 100 ns period
  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ************************************
  // apb master and command helpers
  // ************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    // one-cycle fault pulse of a command stands during this cycle
    fp_seen = fault_pulse;
  endtask : apb

  // record byte write, mirrored in the model
  task automatic put_rec(input int i, input logic [7:0] v);
    rec[i] = v;
    apb(1'b1, 12'h400 + 12'(i * 4), {24'h000000, v});
  endtask : put_rec

  // issue one command, then compare fault, vector, code and mode
  task automatic cmd(input int c, input logic ef, input logic [7:0] ev,
                     input logic [15:0] ec);
    apb(1'b1, vlmp_pkg::REG_COMMAND, 32'(c));
    `CHK("fault pulse", ef, fp_seen)
    `CHK("vector pin", ef ? ev : 8'h00, fault_vector)
    `CHK("code pin", ef ? ec : 16'h0000, fault_code)
    apb(1'b0, vlmp_pkg::REG_RESULT, 32'h00000000);
    `CHK("fault", ef, rd[0])
    if (ef) begin
      `CHK("vector", ev, rd[15:8])
      if (c == 13) begin
        `CHK("code", ec, rd[31:16])
      end
    end
    `CHK("vm result", vm, rd[1])
    `CHK("vm pin", vm, virtual_mode_flag)
  endtask : cmd

  // expected bitmap verdict for a port access of 1, 2 or 4 bytes
  function automatic logic port_denied(input int p, input int s);
    int ptr;
    int idx;
    logic deny;
    ptr = {rec[8'h67], rec[8'h66]};
    deny = 1'b0;
    for (int b = p; b < p + (1 << s); b++) begin
      idx = ptr + b / 8;
      if (idx > lim || idx > 255) begin
        deny = 1'b1;
      end else if (rec[idx][b % 8]) begin
        deny = 1'b1;
      end
    end
    return deny;
  endfunction : port_denied

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    final_report();
  end

  // ************************************
  // main sequence
  // ************************************
  initial begin
    for (int i = 0; i < 256; i++) rec[i] = 8'h00;
    void'($urandom(32'h5598));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, vlmp_pkg::REG_FLAGS, 32'h00000000);
    `CHK("flags reset", vlmp_pkg::FLAGS_RESET, rd)
    apb(1'b0, 12'h020, 32'h00000000);
    `CHK("unmapped", 1'b1, err_seen)
    // enter virtual mode by a wide return at level 0
    apb(1'b1, vlmp_pkg::REG_MODE, 32'h00000001);
    apb(1'b1, vlmp_pkg::REG_FLAGS, 32'h00003002);
    apb(1'b1, vlmp_pkg::REG_OPERAND, 32'h00040000);
    apb(1'b1, vlmp_pkg::REG_GATE, 32'h00023002);
    vm = 1'b1;
    cmd(8, 1'b0, 8'h00, 16'h0000);
    // io level 3: sensitive ops pass, pushed image hides the flag
    for (int c = 4; c <= 6; c++) cmd(c, 1'b0, 8'h00, 16'h0000);
    apb(1'b0, vlmp_pkg::REG_IMAGE, 32'h00000000);
    `CHK("pushed vm", 1'b0, rd[17])
    apb(1'b1, vlmp_pkg::REG_OPERAND, 32'h00003002);
    cmd(7, 1'b0, 8'h00, 16'h0000);
    cmd(1, 1'b1, vlmp_pkg::VEC_GP, 16'h0000);
    cmd(2, 1'b1, vlmp_pkg::VEC_UD, 16'h0000);
    // io level 0: every sensitive op faults, trap ops never do
    apb(1'b1, vlmp_pkg::REG_FLAGS, 32'h00000002);
    for (int c = 3; c <= 8; c++) cmd(c, 1'b1, 8'h0d, 16'h0000);
    for (int c = 9; c <= 11; c++) cmd(c, 1'b0, 8'h00, 16'h0000);
    // port bitmap at 0x70, port 2 denied, terminator at 0x72
    put_rec(8'h66, 8'h70);
    put_rec(8'h67, 8'h00);
    put_rec(8'h70, 8'h04);
    put_rec(8'h71, 8'h00);
    put_rec(8'h72, 8'hff);
    lim = 16'h0072;
    apb(1'b1, vlmp_pkg::REG_LIMIT, 32'(lim));
    for (int k = 0; k < 16; k++) begin
      port = int'($urandom % 16);
      sz = int'($urandom % 3);
      apb(1'b1, vlmp_pkg::REG_OPERAND, 32'(port) | 32'(sz << 16));
      cmd(12, port_denied(port, sz), 8'h0d, 16'h0000);
    end
    apb(1'b1, vlmp_pkg::REG_OPERAND, 32'h00000000);
    cmd(12, port_denied(0, 0), 8'h0d, 16'h0000);
    // pointer beyond the record limit denies every port
    lim = 16'h0060;
    apb(1'b1, vlmp_pkg::REG_LIMIT, 32'(lim));
    cmd(12, 1'b1, 8'h0d, 16'h0000);
    // gate entry: conforming or level 2 target faults with selector
    apb(1'b1, vlmp_pkg::REG_GATE, 32'h00f41234);
    cmd(13, 1'b1, 8'h0d, 16'h1234);
    apb(1'b1, vlmp_pkg::REG_GATE, 32'h00f25678);
    cmd(13, 1'b1, 8'h0d, 16'h5678);
    apb(1'b1, vlmp_pkg::REG_GATE, 32'h00f89abc);
    vm = 1'b0;
    cmd(13, 1'b0, 8'h00, 16'h0000);
    apb(1'b0, vlmp_pkg::REG_IMAGE, 32'h00000000);
    `CHK("saved vm", 1'b1, rd[17])
    // task switches in through both new record types, out through an old type 3 record
    apb(1'b1, vlmp_pkg::REG_OPERAND, 32'h00020002);
    for (int t = 9; t <= 11; t += 2) begin
      apb(1'b1, vlmp_pkg::REG_GATE, 32'(t) << 20);
      vm = 1'b1;
      cmd(14, 1'b0, 8'h00, 16'h0000);
      `CHK("legacy seg", 1'b1, segment_legacy_base)
      apb(1'b1, vlmp_pkg::REG_GATE, 32'h00300000);
      vm = 1'b0;
      cmd(14, 1'b0, 8'h00, 16'h0000);
      apb(1'b0, vlmp_pkg::REG_IMAGE, 32'h00000000);
      `CHK("out image vm", 1'b1, rd[17])
    end
    final_report();
  end

endmodule : tb_vlmp_protect
